// ===== logic/output_sync_timing_monitor.sv
// Output synchronisation timing monitor: APB register bank, time measurement, error counters.
// Assumes all event inputs except the i_run_state level are one-cycle pulses synchronous to i_core_clk.
`timescale 1ns/100ps
`include "otm_cfg.svh"
module output_sync_timing_monitor #(
  parameter otm_pkg::word_t LATE_TOL_NS = `OTM_LATE_TOL_NS
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire otm_pkg::addr_t i_paddr,
  input wire otm_pkg::word_t i_pwdata,
  output otm_pkg::word_t o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Synchronisation events
  input wire logic i_first_sync_pulse,
  input wire logic i_second_sync_pulse,
  input wire logic i_output_buffer_manager,
  input wire logic i_local_timer_tick,
  input wire logic i_outputs_driven,
  input wire logic i_run_state,
  // Interrupt and status
  output logic o_irq,
  output logic o_distributed_time_mode
);
  import otm_pkg::*;

  // ==================================================
  // Declarations
  localparam word_t LATE_TOL_CYC = (LATE_TOL_NS + `OTM_CLK_PERIOD_NS - 32'h1) / `OTM_CLK_PERIOD_NS;
  localparam half_t MODE_MASK = `OTM_RST_MODE_MASK; // Advertised modes

  half_t sync_mode_ff; // Current synchronisation mode
  half_t command_ff; // Measurement command
  logic [`OTM_IRQ_WIDTH-1:0] irq_status_ff; // Sticky events
  logic [`OTM_IRQ_WIDTH-1:0] irq_mask_ff; // Event enables
  logic late_flag_ff; // Outputs late in last cycle
  word_t prdata_ff; // Read data
  logic pslverr_ff; // Error answer
  word_t since_first_ns_ff; // Time since first pulse
  word_t since_second_ns_ff; // Time since second pulse
  word_t since_start_ns_ff; // Time since cycle start
  word_t late_cyc_ff; // Cycles since second pulse
  logic first_seen_ff; // A first pulse has come
  logic second_seen_ff; // Second pulse came in this cycle
  logic start_seen_ff; // A cycle start has come
  logic buf_seen_ff; // Buffer event since last first pulse
  logic on_time_ff; // Outputs driven in tolerance this cycle
  cycle_state_t cyc_state_ff; // Output pending state

  logic dist_mode; // Distributed time mode active
  logic measuring; // Measurement running
  logic cycle_start; // Start of a cycle in current mode
  logic wr_en; // Write taken
  logic rd_en; // Read taken
  logic setup; // Setup phase
  logic meas_clear; // Start of a new measurement
  logic ev_missed; // Missed buffer event
  logic ev_overrun; // Cycle overrun
  logic ev_short; // Too-short pulse gap
  logic ev_late; // Late outputs at cycle close
  logic [`OTM_IRQ_WIDTH-1:0] ev_vec; // All events
  word_t shift_val; // Measured shift time
  word_t cycle_val; // Measured cycle time
  word_t gap_val; // Measured pulse gap
  word_t delay_val; // Measured output delay
  half_t missed_cnt; // Missed event count
  half_t overrun_cnt; // Overrun count
  half_t short_cnt; // Short gap count
  word_t nxt_prdata; // Next read data
  logic nxt_pslverr; // Next error answer

  // ==================================================
  // Helpers
  // Saturating add of one clock period in ns
  function automatic word_t sat_add_ns(input word_t t);
    if (t > (32'hffffffff - `OTM_CLK_PERIOD_NS)) begin
      sat_add_ns = 32'hffffffff;
    end else begin
      sat_add_ns = t + `OTM_CLK_PERIOD_NS;
    end
  endfunction

  // Zero-extend a 16-bit entry to a word
  function automatic word_t ext16(input half_t v);
    ext16 = {16'h0000, v};
  endfunction

  // ==================================================
  // Mode decode
  // Modes two and three are the distributed time modes
  assign dist_mode = (sync_mode_ff == `OTM_MODE_FIRST_PULSE) || (sync_mode_ff == `OTM_MODE_SECOND_PULSE);
  assign o_distributed_time_mode = dist_mode;
  assign measuring = (command_ff == `OTM_CMD_START);

  // Cycle start event picked by the mode
  always_comb begin
    unique case (sync_mode_ff)
      `OTM_MODE_FREE_RUN: cycle_start = i_local_timer_tick;
      `OTM_MODE_BUFFER_EVENT: cycle_start = i_output_buffer_manager;
      `OTM_MODE_FIRST_PULSE: cycle_start = i_first_sync_pulse;
      `OTM_MODE_SECOND_PULSE: cycle_start = i_first_sync_pulse;
      default: cycle_start = 1'b0; // Unknown mode codes run no cycle
    endcase
  end

  // ==================================================
  // APB decode
  assign setup = i_psel && !i_penable;
  assign o_pready = 1'b1; // Zero wait states, data staged at setup
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;
  assign meas_clear = wr_en && (i_paddr == `OTM_OFF_COMMAND) && (i_pwdata[15:0] == `OTM_CMD_START) && !measuring;

  // Read mux and address check
  always_comb begin
    nxt_prdata = 32'h00000000;
    nxt_pslverr = 1'b0;
    unique case (i_paddr)
      `OTM_OFF_SYNC_MODE: nxt_prdata = ext16(sync_mode_ff);
      `OTM_OFF_SHIFT_TIME: nxt_prdata = shift_val;
      `OTM_OFF_MODE_MASK: nxt_prdata = ext16(MODE_MASK);
      `OTM_OFF_MIN_CYCLE: nxt_prdata = cycle_val;
      `OTM_OFF_GAP_MIN: nxt_prdata = gap_val;
      `OTM_OFF_MIN_DELAY: nxt_prdata = `OTM_RST_MIN_DELAY;
      `OTM_OFF_COMMAND: nxt_prdata = ext16(command_ff);
      `OTM_OFF_MAX_DELAY: nxt_prdata = delay_val;
      `OTM_OFF_MISSED: nxt_prdata = ext16(missed_cnt);
      `OTM_OFF_OVERRUN: nxt_prdata = ext16(overrun_cnt);
      `OTM_OFF_SHORT: nxt_prdata = ext16(short_cnt);
      `OTM_OFF_IRQ_STATUS: nxt_prdata = {28'h0000000, irq_status_ff};
      `OTM_OFF_IRQ_MASK: nxt_prdata = {28'h0000000, irq_mask_ff};
      `OTM_OFF_LATE_FLAG: nxt_prdata = {31'h00000000, late_flag_ff};
      default: nxt_pslverr = 1'b1; // Unmapped address
    endcase
  end

  // Read data and error staged in the setup cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= i_pwrite ? 32'h00000000 : nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pslverr = pslverr_ff && i_psel && i_penable;

  // ==================================================
  // Writable registers
  // Mode register
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_mode_ff <= `OTM_RST_SYNC_MODE;
    end else if (wr_en && (i_paddr == `OTM_OFF_SYNC_MODE)) begin
      sync_mode_ff <= i_pwdata[15:0];
    end
  end

  // Measurement command
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      command_ff <= `OTM_RST_COMMAND;
    end else if (wr_en && (i_paddr == `OTM_OFF_COMMAND)) begin
      command_ff <= i_pwdata[15:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask_ff <= '0;
    end else if (wr_en && (i_paddr == `OTM_OFF_IRQ_MASK)) begin
      irq_mask_ff <= i_pwdata[`OTM_IRQ_WIDTH-1:0];
    end
  end

  // ==================================================
  // Interval timers in ns, late check counter in cycles
  // Time since the first pulse
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      since_first_ns_ff <= 32'h00000000;
    end else if (i_first_sync_pulse) begin
      since_first_ns_ff <= `OTM_CLK_PERIOD_NS;
    end else begin
      since_first_ns_ff <= sat_add_ns(since_first_ns_ff);
    end
  end

  // Time since the second pulse
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      since_second_ns_ff <= 32'h00000000;
    end else if (i_second_sync_pulse) begin
      since_second_ns_ff <= `OTM_CLK_PERIOD_NS;
    end else begin
      since_second_ns_ff <= sat_add_ns(since_second_ns_ff);
    end
  end

  // Time since the cycle start
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      since_start_ns_ff <= 32'h00000000;
    end else if (cycle_start) begin
      since_start_ns_ff <= `OTM_CLK_PERIOD_NS;
    end else begin
      since_start_ns_ff <= sat_add_ns(since_start_ns_ff);
    end
  end

  // Cycles since second pulse for the late check, saturating
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      late_cyc_ff <= 32'h00000000;
    end else if (i_second_sync_pulse) begin
      late_cyc_ff <= 32'h00000000;
    end else if (late_cyc_ff != 32'hffffffff) begin
      late_cyc_ff <= late_cyc_ff + 32'h1;
    end
  end

  // ==================================================
  // Sequence tracking
  // Seen flags for first pulse, cycle start and buffer events
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_seen_ff <= 1'b0;
      start_seen_ff <= 1'b0;
      buf_seen_ff <= 1'b0;
    end else begin
      first_seen_ff <= first_seen_ff || i_first_sync_pulse;
      start_seen_ff <= start_seen_ff || cycle_start;
      if (i_first_sync_pulse) begin
        buf_seen_ff <= i_output_buffer_manager; // Event in the same cycle counts for the next
      end else if (i_output_buffer_manager) begin
        buf_seen_ff <= 1'b1;
      end
    end
  end

  // Second pulse and on-time tracking within a cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      second_seen_ff <= 1'b0;
      on_time_ff <= 1'b0;
    end else if (i_first_sync_pulse) begin
      second_seen_ff <= 1'b0;
      on_time_ff <= 1'b0;
    end else begin
      if (i_second_sync_pulse) begin
        second_seen_ff <= 1'b1;
      end
      if (i_outputs_driven && second_seen_ff && (late_cyc_ff < LATE_TOL_CYC)) begin
        on_time_ff <= 1'b1;
      end
    end
  end

  // Output pending state: a start opens a cycle, driven outputs close it
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_state_ff <= cyc_idle;
    end else begin
      unique case (cyc_state_ff)
        cyc_idle: begin
          if (cycle_start) begin
            cyc_state_ff <= cyc_wait_out;
          end
        end
        cyc_wait_out: begin
          if (i_outputs_driven && !cycle_start) begin
            cyc_state_ff <= cyc_idle;
          end
        end
      endcase
    end
  end

  // ==================================================
  // Error events
  assign ev_missed = dist_mode && i_run_state && i_first_sync_pulse && first_seen_ff && !buf_seen_ff;
  assign ev_overrun = i_run_state && cycle_start && (cyc_state_ff == cyc_wait_out);
  assign ev_short = dist_mode && i_second_sync_pulse && first_seen_ff && (since_first_ns_ff < gap_val);
  assign ev_late = dist_mode && i_first_sync_pulse && first_seen_ff && !on_time_ff;
  assign ev_vec = {ev_late, ev_short, ev_overrun, ev_missed};

  // Late flag updated at each cycle close in distributed mode
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      late_flag_ff <= 1'b0;
    end else if (dist_mode && i_first_sync_pulse && first_seen_ff) begin
      late_flag_ff <= !on_time_ff;
    end
  end

  // Sticky status; a read clears only the bits it returned, new events win
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status_ff <= '0;
    end else if (rd_en && (i_paddr == `OTM_OFF_IRQ_STATUS)) begin
      irq_status_ff <= (irq_status_ff & ~prdata_ff[`OTM_IRQ_WIDTH-1:0]) | ev_vec;
    end else begin
      irq_status_ff <= irq_status_ff | ev_vec;
    end
  end

  assign o_irq = |(irq_status_ff & irq_mask_ff);

  // ==================================================
  // Error counters
  sat_counter #(.W(16)) u_missed_cnt (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_inc(ev_missed),
    .o_count(missed_cnt)
  );

  sat_counter #(.W(16)) u_overrun_cnt (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_inc(ev_overrun),
    .o_count(overrun_cnt)
  );

  sat_counter #(.W(16)) u_short_cnt (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_inc(ev_short),
    .o_count(short_cnt)
  );

  // ==================================================
  // Measured maxima
  // Shift: first pulse to outputs driven, distributed mode
  max_tracker #(.W(32), .RESET_VAL(`OTM_RST_SHIFT_TIME)) u_shift (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clear(meas_clear),
    .i_sample_valid(measuring && dist_mode && i_outputs_driven && first_seen_ff),
    .i_sample(since_first_ns_ff),
    .o_value(shift_val)
  );

  // Cycle: start to start
  max_tracker #(.W(32), .RESET_VAL(`OTM_RST_MIN_CYCLE)) u_cycle (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clear(meas_clear),
    .i_sample_valid(measuring && cycle_start && start_seen_ff),
    .i_sample(since_start_ns_ff),
    .o_value(cycle_val)
  );

  // Gap: first pulse to second pulse, distributed mode
  max_tracker #(.W(32), .RESET_VAL(`OTM_RST_GAP_MIN)) u_gap (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clear(meas_clear),
    .i_sample_valid(measuring && dist_mode && i_second_sync_pulse && first_seen_ff),
    .i_sample(since_first_ns_ff),
    .o_value(gap_val)
  );

  // Delay: second pulse to outputs driven, distributed mode
  max_tracker #(.W(32), .RESET_VAL(`OTM_RST_MAX_DELAY)) u_delay (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clear(meas_clear),
    .i_sample_valid(measuring && dist_mode && i_outputs_driven && second_seen_ff),
    .i_sample(since_second_ns_ff),
    .o_value(delay_val)
  );
endmodule

// ===== logic/otm_cfg.svh
// Constants of the output synchronisation timing monitor: offsets, fields, resets, timing.
// Assumes a 250 MHz core clock and a 32-bit APB register bus.
//
// Functional notes
// - Mode codes: free, buffer event, pulse one, two
// - Report first-pulse-to-output shift time, distributed mode
// - Supported-modes word resets to 0x0807, bits 0,1
// - Modes bits 3:2 equal 01: distributed mode
// - Modes bits 5:4 equal 10: second-pulse shift
// - Modes bit 14: times measurable by command
// - Minimum cycle time reads 66000 ns default
// - Report minimum gap between both pulses
// - Report minimum second-pulse-to-output delay
// - Command 1 starts measuring, 0 stops it
// - While measuring, timing entries hold largest values
// - New measurement clears previously held maxima first
// - Report second-pulse-to-output delay, distributed mode
// - Count missed buffer events in run state
// - Count overrun or early cycles in run state
// - Count too-short gaps between both pulses
// - Late flag set when outputs driven late
`ifndef OTM_CFG_SVH
`define OTM_CFG_SVH

// ==================================================
// Register byte offsets
`define OTM_OFF_SYNC_MODE 12'h004
`define OTM_OFF_SHIFT_TIME 12'h00c
`define OTM_OFF_MODE_MASK 12'h010
`define OTM_OFF_MIN_CYCLE 12'h014
`define OTM_OFF_GAP_MIN 12'h018
`define OTM_OFF_MIN_DELAY 12'h01c
`define OTM_OFF_COMMAND 12'h020
`define OTM_OFF_MAX_DELAY 12'h024
`define OTM_OFF_MISSED 12'h02c
`define OTM_OFF_OVERRUN 12'h030
`define OTM_OFF_SHORT 12'h034
`define OTM_OFF_IRQ_STATUS 12'h040
`define OTM_OFF_IRQ_MASK 12'h044
`define OTM_OFF_LATE_FLAG 12'h080

// ==================================================
// Mode codes of the current synchronisation mode
`define OTM_MODE_FREE_RUN 16'h0000
`define OTM_MODE_BUFFER_EVENT 16'h0001
`define OTM_MODE_FIRST_PULSE 16'h0002
`define OTM_MODE_SECOND_PULSE 16'h0003

// ==================================================
// Reset values
`define OTM_RST_SYNC_MODE 16'h0001
`define OTM_RST_SHIFT_TIME 32'h00000000
`define OTM_RST_MODE_MASK 16'h0807
`define OTM_RST_MIN_CYCLE 32'h000101d0
`define OTM_RST_GAP_MIN 32'h00000000
`define OTM_RST_MIN_DELAY 32'h00000000
`define OTM_RST_COMMAND 16'h0000
`define OTM_RST_MAX_DELAY 32'h00000000
`define OTM_RST_COUNT 16'h0000

// ==================================================
// Command values
`define OTM_CMD_STOP 16'h0000
`define OTM_CMD_START 16'h0001

// ==================================================
// Supported-modes fields
`define OTM_MASK_FREE_BIT 0
`define OTM_MASK_BUFFER_BIT 1
`define OTM_MASK_DIST_LSB 2
`define OTM_MASK_SHIFT_LSB 4
`define OTM_MASK_DYNAMIC_BIT 14

// ==================================================
// Interrupt status bit positions
`define OTM_IRQ_MISSED_BIT 0
`define OTM_IRQ_OVERRUN_BIT 1
`define OTM_IRQ_SHORT_BIT 2
`define OTM_IRQ_LATE_BIT 3
`define OTM_IRQ_WIDTH 4

// ==================================================
// Timing
`define OTM_CLK_PERIOD_NS 32'h00000004
`define OTM_LATE_TOL_NS 32'h000003e8

`endif

// ===== logic/otm_pkg.sv
// Types shared by the output synchronisation timing monitor.
// Assumes otm_cfg.svh provides the numeric constants.
package otm_pkg;
  typedef logic [31:0] word_t; // One register word
  typedef logic [15:0] half_t; // 16-bit entry
  typedef logic [11:0] addr_t; // APB byte address
  typedef enum logic [1:0] {cyc_idle, cyc_wait_out} cycle_state_t; // Output pending tracker
endpackage

// ===== logic/max_tracker.sv
// Holder of a measured maximum time with a reset default and a clear.
// Assumes samples arrive as single-cycle strobes in the core clock domain.
`timescale 1ns/100ps
module max_tracker #(
  parameter int W = 32,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_sample_valid,
  input wire logic [W-1:0] i_sample,
  output logic [W-1:0] o_value
);
  logic [W-1:0] value_ff; // Held maximum

  // ==================================================
  // Maximum holder
  // Clear to zero at a new start, otherwise keep the largest sample
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      value_ff <= RESET_VAL;
    end else if (i_clear) begin
      value_ff <= '0;
    end else if (i_sample_valid && (i_sample > value_ff)) begin
      value_ff <= i_sample;
    end
  end

  assign o_value = value_ff;
endmodule

// ===== logic/sat_counter.sv
// Saturating event counter cleared only by reset.
// Assumes increments are single-cycle strobes in the core clock domain.
`timescale 1ns/100ps
module sat_counter #(
  parameter int W = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_inc,
  output logic [W-1:0] o_count
);
  logic [W-1:0] count_ff; // Event count

  // ==================================================
  // Counter
  // Stops at all ones instead of wrapping
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_ff <= '0;
    end else if (i_inc && (count_ff != {W{1'b1}})) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  assign o_count = count_ff;
endmodule

// ===== testbench/otm_checker.sv
// Assertions on the monitor's APB answers and its mode decode.
// Sees only top-level ports; bound to every monitor instance below.
`timescale 1ns/100ps
`include "otm_cfg.svh"
module otm_checker
  import otm_pkg::*;
#(
  parameter word_t LATE_TOL_NS = `OTM_LATE_TOL_NS
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire addr_t i_paddr,
  input wire word_t i_pwdata,
  input wire word_t o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_distributed_time_mode
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // ==================================================
  // Bus phase decodes
  wire rd_setup = i_psel && !i_penable && !i_pwrite;
  wire mode_wr = i_psel && i_penable && i_pwrite && i_paddr == `OTM_OFF_SYNC_MODE;
  chk_ready_in_access: assert property (i_psel && i_penable |-> o_pready)
    else $error("access phase without ready");
  chk_error_in_access: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("error outside access phase");
  chk_unmapped_refused: assert property (rd_setup && i_paddr == 12'h008 |=>
      !i_penable || (o_pslverr && o_prdata == 32'h0))
    else $error("unmapped read not refused");
  chk_modes_word: assert property (rd_setup && i_paddr == `OTM_OFF_MODE_MASK |=>
      o_prdata == 32'h00000807)
    else $error("supported modes word wrong");
  chk_min_delay_zero: assert property (rd_setup && i_paddr == `OTM_OFF_MIN_DELAY |=> o_prdata == 32'h0)
    else $error("minimum delay not zero");
  chk_late_upper_zero: assert property (rd_setup && i_paddr == `OTM_OFF_LATE_FLAG |=> o_prdata[31:1] == 31'h0)
    else $error("late flag upper bits set");
  chk_mode_decode: assert property (mode_wr |=> o_distributed_time_mode ==
      ($past(i_pwdata[15:0]) == 16'h0002 || $past(i_pwdata[15:0]) == 16'h0003))
    else $error("distributed mode decode wrong");
  chk_mode_hold: assert property ($changed(o_distributed_time_mode) |-> $past(mode_wr))
    else $error("distributed mode changed without write");
  chk_rdata_hold: assert property (!$stable(o_prdata) |-> $past(i_psel && !i_penable))
    else $error("read data changed outside setup");
endmodule
bind output_sync_timing_monitor otm_checker #(.LATE_TOL_NS(LATE_TOL_NS)) chk (.i_core_clk, .i_rst_n, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_distributed_time_mode);

// ===== testbench/otm_master_model.sv
// Behavioural bus master: per request one frame of pulses, buffer event and output drive.
// Assumes the bench holds i_go until o_done and keeps gap plus delay below the period.
`timescale 1ns/100ps
module otm_master_model #(
  parameter int PERIOD = 40
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [7:0] i_gap,
  input wire logic [7:0] i_delay,
  input wire logic i_buf_en,
  input wire logic i_drv_en,
  output logic o_done,
  output logic o_first_sync_pulse,
  output logic o_second_sync_pulse,
  output logic o_output_buffer_manager,
  output logic o_local_timer_tick,
  output logic o_outputs_driven
);
  logic busy_ff; // Frame in progress
  logic [7:0] cnt_ff; // Cycle within frame
  // Frame counter, idle until asked
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (!busy_ff) begin
      busy_ff <= i_go;
      cnt_ff <= 8'h00;
    end else begin
      busy_ff <= (cnt_ff != 8'(PERIOD - 1));
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  // Pulses placed along the frame
  always_comb begin
    o_first_sync_pulse = busy_ff && cnt_ff == 8'h00;
    o_local_timer_tick = busy_ff && cnt_ff == 8'h00;
    o_output_buffer_manager = busy_ff && i_buf_en && cnt_ff == 8'h02;
    o_second_sync_pulse = busy_ff && cnt_ff == i_gap;
    o_outputs_driven = busy_ff && i_drv_en && cnt_ff == i_gap + i_delay;
    o_done = busy_ff && cnt_ff == 8'(PERIOD - 1);
  end
endmodule

// ===== testbench/output_sync_timing_monitor_tb.sv
// Self-checking bench: register map, measurement, error counters and interrupt.
// Assumes the master model drives all event inputs; the bench owns APB and run state.
`timescale 1ns/100ps
module output_sync_timing_monitor_tb;
  import otm_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  addr_t i_paddr = '0;
  word_t i_pwdata = '0;
  logic i_run_state = 1'b0;
  logic go = 1'b0;
  logic buf_en = 1'b1;
  logic drv_en = 1'b1;
  logic [7:0] gap = 8'h05;
  logic [7:0] dly = 8'h01;
  word_t o_prdata;
  logic o_pready, o_pslverr, o_irq, o_distributed_time_mode, done;
  logic i_first_sync_pulse, i_second_sync_pulse, i_output_buffer_manager, i_local_timer_tick, i_outputs_driven;
  int mismatches = 0;
  int num_checks = 0;
  word_t seed = 32'ha4ec;
  logic slv;
  addr_t rst_addr [12] = '{12'h004, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h020, 12'h024, 12'h02c,
    12'h030, 12'h034, 12'h080};
  word_t rst_val [12] = '{32'h1, 32'h0, 32'h807, 32'h101d0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  always #2 i_core_clk = ~i_core_clk;
  output_sync_timing_monitor #(.LATE_TOL_NS(32'h00000028)) dut (.i_core_clk, .i_rst_n, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_first_sync_pulse, .i_second_sync_pulse,
    .i_output_buffer_manager, .i_local_timer_tick, .i_outputs_driven, .i_run_state, .o_irq, .o_distributed_time_mode);
  otm_master_model master (.i_core_clk, .i_rst_n, .i_go(go), .i_gap(gap), .i_delay(dly), .i_buf_en(buf_en),
    .i_drv_en(drv_en), .o_done(done), .o_first_sync_pulse(i_first_sync_pulse),
    .o_second_sync_pulse(i_second_sync_pulse), .o_output_buffer_manager(i_output_buffer_manager),
    .o_local_timer_tick(i_local_timer_tick), .o_outputs_driven(i_outputs_driven));
  // Random source
  function automatic word_t xs(input word_t x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic word_t mx(input word_t a, input word_t b);
    return (a > b) ? a : b;
  endfunction
  // Status expected after the run-state phase
  function automatic word_t irq_exp(input int sh);
    return 32'hb | ((sh > 0) ? 32'h4 : 32'h0);
  endfunction
  task automatic check(input word_t got, input word_t exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is sampled
  task automatic apb(input addr_t a, input logic w, input word_t d, output word_t r);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    r = o_prdata;
    slv = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 50) check(32'h0, 32'h1);
  endtask
  task automatic wr(input addr_t a, input word_t d);
    word_t r;
    apb(a, 1'b1, d, r);
  endtask
  task automatic rd(input addr_t a, input word_t exp);
    word_t r;
    apb(a, 1'b0, 32'h0, r);
    check(r, exp);
  endtask
  // One frame from the master model
  task automatic frame(input logic [7:0] g, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    gap <= g;
    dly <= d;
    go <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (done !== 1'b1 && n < 200);
    go <= 1'b0;
    if (n >= 200) check(32'h0, 32'h1);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_core_clk);
    mismatches++;
    complete_run();
  end
  initial begin
    word_t ms, mg, md, g, d;
    int sh;
    ms = '0;
    mg = '0;
    md = '0;
    sh = 0;
    repeat (8) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    foreach (rst_addr[i]) rd(rst_addr[i], rst_val[i]);
    rd(12'h008, 32'h0);
    check({31'h0, slv}, 32'h1);
    seed = xs(seed);
    wr(12'h010, seed);
    rd(12'h010, 32'h807);
    wr(12'h014, seed);
    rd(12'h014, 32'h101d0);
    wr(12'h01c, seed);
    rd(12'h01c, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(12'h004, word_t'(m));
      rd(12'h004, word_t'(m));
      check({31'h0, o_distributed_time_mode}, {31'h0, m >= 2});
    end
    wr(12'h020, 32'h1);
    rd(12'h020, 32'h1);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      g = 3 + seed % 10;
      d = 1 + (seed >> 8) % 9;
      if (4 * g < mg) sh++;
      mg = mx(mg, 4 * g);
      ms = mx(ms, 4 * (g + d));
      md = mx(md, 4 * d);
      frame(g[7:0], d[7:0]);
    end
    wr(12'h020, 32'h0);
    rd(12'h00c, ms);
    rd(12'h018, mg);
    rd(12'h024, md);
    rd(12'h014, 32'h000000a8);
    rd(12'h034, word_t'(sh));
    rd(12'h080, 32'h0);
    wr(12'h020, 32'h1);
    rd(12'h00c, 32'h0);
    rd(12'h018, 32'h0);
    wr(12'h020, 32'h0);
    i_run_state <= 1'b1;
    buf_en <= 1'b0;
    drv_en <= 1'b0;
    repeat (4) frame(8'h05, 8'h01);
    i_run_state <= 1'b0;
    rd(12'h02c, 32'h3);
    rd(12'h030, 32'h3);
    rd(12'h080, 32'h1);
    rd(12'h034, word_t'(sh));
    wr(12'h044, 32'h0);
    @(negedge i_core_clk);
    check({31'h0, o_irq}, 32'h0);
    wr(12'h044, 32'hf);
    @(negedge i_core_clk);
    check({31'h0, o_irq}, 32'h1);
    rd(12'h040, irq_exp(sh));
    @(negedge i_core_clk);
    check({31'h0, o_irq}, 32'h0);
    complete_run();
  end
endmodule
